// ### rtl/acr_pkg.sv
// Package with register map, field layout, codes and timing constants of the converter control.
package acr_pkg;

  // Register byte addresses on the APB slave.
  localparam logic [7:0] ADDR_CHAN_START = 8'h00;
  localparam logic [7:0] ADDR_CLK_FMT    = 8'h04;
  localparam logic [7:0] ADDR_RES_HIGH   = 8'h08;
  localparam logic [7:0] ADDR_RES_LOW    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;

  // Field positions of the channel/start register.
  localparam int CH_ENABLE_BIT = 0;
  localparam int CH_START_BIT  = 1;
  localparam int CH_SEL_LSB    = 2;
  localparam int CH_SEL_MSB    = 7;

  // Field positions of the clock/format/reference register.
  localparam int REF_LSB     = 0;
  localparam int REF_MSB     = 1;
  localparam int JUSTIFY_BIT = 2;
  localparam int CLKSEL_LSB  = 4;
  localparam int CLKSEL_MSB  = 6;
  localparam logic [7:0] CLK_FMT_WMASK = 8'h77;

  // Reset values.
  localparam logic [7:0] CHAN_START_RST = 8'h00;
  localparam logic [7:0] CLK_FMT_RST    = 8'h00;

  // Clock select codes.
  localparam logic [2:0] CLKSEL_DIV8  = 3'h1;
  localparam logic [2:0] CLKSEL_DIV16 = 3'h5;
  localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
  localparam logic [2:0] CLKSEL_DIV64 = 3'h6;
  localparam logic [1:0] CLKSEL_RC_LOW = 2'h3;

  // Divide ratios.
  localparam logic [6:0] DIV_8   = 7'h08;
  localparam logic [6:0] DIV_16  = 7'h10;
  localparam logic [6:0] DIV_32  = 7'h20;
  localparam logic [6:0] DIV_64  = 7'h40;

  // Reference select codes.
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_SUPPLY   = 2'h1;
  localparam logic [1:0] REF_EXT_HI   = 2'h2;

  // Channel select landmarks.
  localparam logic [5:0] CH_PORT_LAST    = 6'h07;
  localparam logic [5:0] CH_TEMP_SENSOR  = 6'h10;
  localparam logic [5:0] CH_BANDGAP      = 6'h11;
  localparam logic [5:0] CH_RAW_CURRENT  = 6'h1E;
  localparam logic [5:0] CH_CLAMP_REF    = 6'h1F;

  // Conversion timing in conversion-bit periods.
  localparam logic [3:0] CONV_PERIODS  = 4'hB;
  localparam logic [3:0] ABORT_PERIODS = 4'h2;

  // Converter sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01,
    ST_HOLDOFF = 2'b10
  } acr_state_e;

endpackage

// ### rtl/acr_tick_if.sv
// Interface carrying the conversion-bit tick from the divider to the controller.
`timescale 1ns/100ps
interface acr_tick_if;
  logic [2:0] clockSelect;
  logic       running;
  logic       tick;
  logic       validSelect;

  modport ctrl (output clockSelect, output running, input tick, input validSelect);
  modport div  (input clockSelect, input running, output tick, output validSelect);
endinterface // acr_tick_if

// ### rtl/acr_bit_clock.sv
// Conversion-bit clock divider producing a one-cycle tick enable.
`timescale 1ns/100ps
module acr_bit_clock (
  // Clock and reset.
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  // Internal oscillator edge, already on core_clk.
  input  wire logic  rcTick,
  // Link to the controller.
  acr_tick_if.div    tickIf
);

  logic [6:0] divCount;
  logic [6:0] ratio;
  logic       rcMode;
  logic       srcTick;
  logic       wrap;

  assign rcMode = (tickIf.clockSelect[1:0] == acr_pkg::CLKSEL_RC_LOW);
  assign ratio = (tickIf.clockSelect == acr_pkg::CLKSEL_DIV8)  ? acr_pkg::DIV_8  :
                 (tickIf.clockSelect == acr_pkg::CLKSEL_DIV16) ? acr_pkg::DIV_16 :
                 (tickIf.clockSelect == acr_pkg::CLKSEL_DIV32) ? acr_pkg::DIV_32 :
                 (tickIf.clockSelect == acr_pkg::CLKSEL_DIV64) ? acr_pkg::DIV_64 :
                 rcMode ? acr_pkg::DIV_16 : 7'h00;
  assign tickIf.validSelect = (ratio != 7'h00);
  assign srcTick = rcMode ? rcTick : 1'b1;
  assign wrap    = (divCount == ratio - 7'h01);
  assign tickIf.tick = tickIf.running && tickIf.validSelect && srcTick && wrap;

  // Counter advances on each source edge while the sequencer is in convert or hold-off.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCount <= 7'h00;
    end else if (!tickIf.running || !tickIf.validSelect) begin
      divCount <= 7'h00;
    end else if (srcTick) begin
      divCount <= wrap ? 7'h00 : divCount + 7'h01;
    end
  end

endmodule // acr_bit_clock

// ### rtl/acr_converter_control.sv
// Converter control registers, sequencer and APB slave.
`timescale 1ns/100ps
module acr_converter_control (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog front end.
  input  wire logic        rcOscPin,
  input  wire logic        compareIn,
  output logic      [5:0]  channelSelect,
  output logic             channelValid,
  output logic             tempSensorOn,
  output logic             bandgapOn,
  output logic             rawCurrentOn,
  output logic             clampRefOn,
  output logic      [1:0]  referenceSelect,
  output logic             externalRefOn,
  output logic             converterPowered,
  output logic             sampleHold,
  output logic      [9:0]  trialCode,
  // Interrupt.
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0] chanStart;
  logic [7:0] clkFmt;
  logic [9:0] result;
  logic       doneStatus;
  logic       doneMask;
  acr_pkg::acr_state_e state;
  logic [3:0] periodCount;
  logic [9:0] sarReg;
  logic [9:0] sarBit;
  logic       rcSync1;
  logic       rcSync2;
  logic       rcPrev;
  logic       cmpSync1;
  logic       cmpSync2;

  acr_tick_if tickIf ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic       wrEn;
  logic       rdEn;
  logic       hitChan;
  logic       hitClk;
  logic       hitHigh;
  logic       hitLow;
  logic       hitStat;
  logic       hitMask;
  logic       hitAny;
  logic       enableBit;
  logic       startBit;
  logic       startWrite;
  logic       swAbort;
  logic       convDone;
  logic [15:0] justified;
  logic [7:0] readByte;

  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && !pwrite;
  assign hitChan = (paddr == acr_pkg::ADDR_CHAN_START);
  assign hitClk  = (paddr == acr_pkg::ADDR_CLK_FMT);
  assign hitHigh = (paddr == acr_pkg::ADDR_RES_HIGH);
  assign hitLow  = (paddr == acr_pkg::ADDR_RES_LOW);
  assign hitStat = (paddr == acr_pkg::ADDR_IRQ_STATUS);
  assign hitMask = (paddr == acr_pkg::ADDR_IRQ_MASK);
  assign hitAny  = hitChan | hitClk | hitHigh | hitLow | hitStat | hitMask;

  // Slave answers in the first access cycle; unmapped addresses flag an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hitAny;

  ////////////////////////////////////////////////////////////////////////////
  // Control field views.
  assign enableBit = chanStart[acr_pkg::CH_ENABLE_BIT];
  assign startBit  = chanStart[acr_pkg::CH_START_BIT];
  assign startWrite = wrEn && hitChan && pwdata[acr_pkg::CH_START_BIT];
  assign swAbort  = wrEn && hitChan && !pwdata[acr_pkg::CH_START_BIT] &&
                    (state == acr_pkg::ST_CONVERT);
  // Done after the eleventh bit period.
  assign convDone = (state == acr_pkg::ST_CONVERT) && tickIf.tick &&
                    (periodCount == acr_pkg::CONV_PERIODS - 4'h1) && !swAbort;

  ////////////////////////////////////////////////////////////////////////////
  // Result justification.
  // Right justify when select bit set.
  assign justified = clkFmt[acr_pkg::JUSTIFY_BIT] ? {6'h00, result} : {result, 6'h00};

  // Read multiplexer.
  assign readByte = hitChan ? chanStart :
                    hitClk  ? clkFmt :
                    hitHigh ? justified[15:8] :
                    hitLow  ? justified[7:0] :
                    hitStat ? {7'h00, doneStatus} :
                    hitMask ? {7'h00, doneMask} : 8'h00;

  // Read data is registered during the setup cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn && !penable) begin
      prdata <= {24'h00_0000, readByte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel/start register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chanStart <= acr_pkg::CHAN_START_RST;
    end else if (wrEn && hitChan) begin
      // Start ignored while disabled or holding off.
      chanStart <= {pwdata[7:2],
                    pwdata[acr_pkg::CH_START_BIT] && pwdata[acr_pkg::CH_ENABLE_BIT] &&
                    (state != acr_pkg::ST_HOLDOFF) && tickIf.validSelect,
                    pwdata[acr_pkg::CH_ENABLE_BIT]};
    end else if (convDone || !enableBit) begin
      chanStart[acr_pkg::CH_START_BIT] <= 1'b0;
    end
  end

  // Clock/format/reference register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkFmt <= acr_pkg::CLK_FMT_RST;
    end else if (wrEn && hitClk) begin
      clkFmt <= pwdata[7:0] & acr_pkg::CLK_FMT_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask; a new event wins over a clear.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      doneStatus <= 1'b0;
      doneMask   <= 1'b0;
    end else begin
      doneStatus <= convDone || (doneStatus && !(wrEn && hitStat && pwdata[0]));
      if (wrEn && hitMask) begin
        doneMask <= pwdata[0];
      end
    end
  end

  assign irq = doneStatus && doneMask;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the oscillator pin and comparator.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcSync1  <= 1'b0;
      rcSync2  <= 1'b0;
      rcPrev   <= 1'b0;
      cmpSync1 <= 1'b0;
      cmpSync2 <= 1'b0;
    end else begin
      rcSync1  <= rcOscPin;
      rcSync2  <= rcSync1;
      rcPrev   <= rcSync2;
      cmpSync1 <= compareIn;
      cmpSync2 <= cmpSync1;
    end
  end

  // Divider sees the clock select field and runs in convert or hold-off.
  assign tickIf.clockSelect = clkFmt[acr_pkg::CLKSEL_MSB:acr_pkg::CLKSEL_LSB];
  assign tickIf.running = (state != acr_pkg::ST_IDLE);

  acr_bit_clock uBitClock (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .rcTick   (rcSync2 && !rcPrev),
    .tickIf   (tickIf)
  );

  // Trial word after the current bit is decided; the last decision must reach the result.
  logic [9:0] next_sarReg;
  assign next_sarReg = (cmpSync2 ? sarReg : (sarReg & ~sarBit)) | (sarBit >> 1);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer with successive approximation.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= acr_pkg::ST_IDLE;
      periodCount <= 4'h0;
      sarReg      <= 10'h000;
      sarBit      <= 10'h000;
      result      <= 10'h000;
    end else begin
      unique case (state)
        acr_pkg::ST_IDLE: begin
          periodCount <= 4'h0;
          if (startBit && enableBit) begin
            state  <= acr_pkg::ST_CONVERT;
            sarReg <= 10'h200;
            sarBit <= 10'h200;
          end
        end
        acr_pkg::ST_CONVERT: begin
          if (!enableBit) begin
            state <= acr_pkg::ST_IDLE;
          end else if (swAbort) begin
            state       <= acr_pkg::ST_HOLDOFF;
            periodCount <= 4'h0;
          end else if (tickIf.tick) begin
            periodCount <= periodCount + 4'h1;
            if (periodCount != 4'h0 && sarBit != 10'h000) begin
              sarReg <= next_sarReg;
              sarBit <= sarBit >> 1;
            end
            if (convDone) begin
              result <= next_sarReg;
              state  <= acr_pkg::ST_IDLE;
            end
          end
        end
        acr_pkg::ST_HOLDOFF: begin
          if (!enableBit) begin
            state <= acr_pkg::ST_IDLE;
          end else if (tickIf.tick) begin
            periodCount <= periodCount + 4'h1;
            if (periodCount == acr_pkg::ABORT_PERIODS - 4'h1) begin
              state <= acr_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state <= acr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog front-end controls.
  logic [5:0] chSel;
  assign chSel = chanStart[acr_pkg::CH_SEL_MSB:acr_pkg::CH_SEL_LSB];
  assign channelSelect = chSel;
  // Codes above the clamp reference are unimplemented.
  assign channelValid  = (chSel <= acr_pkg::CH_CLAMP_REF);
  assign clampRefOn    = (chSel == acr_pkg::CH_CLAMP_REF);
  assign tempSensorOn  = (chSel == acr_pkg::CH_TEMP_SENSOR);
  assign bandgapOn     = (chSel == acr_pkg::CH_BANDGAP);
  assign rawCurrentOn  = (chSel == acr_pkg::CH_RAW_CURRENT);
  assign referenceSelect = clkFmt[acr_pkg::REF_MSB:acr_pkg::REF_LSB];
  assign externalRefOn   = (referenceSelect >= acr_pkg::REF_EXT_HI);
  assign converterPowered = enableBit;
  assign sampleHold = (state == acr_pkg::ST_CONVERT);
  assign trialCode  = sarReg;

endmodule // acr_converter_control

// ### test/acr_ctrl_chk.sv
// Checker of the converter control block at its ports.
`timescale 1ns/100ps
module acr_ctrl_chk (
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       rst_n,
  // APB slave.
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  // Front end.
  input wire logic [5:0] channelSelect,
  input wire logic       channelValid,
  input wire logic       tempSensorOn,
  input wire logic       bandgapOn,
  input wire logic       rawCurrentOn,
  input wire logic       clampRefOn,
  input wire logic [1:0] referenceSelect,
  input wire logic       externalRefOn,
  input wire logic       converterPowered,
  input wire logic       sampleHold
);
  // All checks sample on the core clock outside reset.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Whether the bus address hits a register.
  wire logic mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  ////////////////////////////////////////////////////////////
  // An access phase errors exactly where no register answers.
  err_map_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr disagrees with the map");
  conv_min_a: assert property ($rose(sampleHold) |-> sampleHold [*8])
    else $error("conversion ended too soon");
  conv_end_a: assert property ($rose(sampleHold) |-> ##[1:1000] !sampleHold)
    else $error("conversion never ended");
  off_idle_a: assert property (!converterPowered |=> !sampleHold)
    else $error("converter sampling while disabled");
  ext_ref_a: assert property (externalRefOn == referenceSelect[1])
    else $error("external reference decode wrong");
  temp_decode_a: assert property ((tempSensorOn == (channelSelect == 6'h10))
    && (bandgapOn == (channelSelect == 6'h11))) else $error("sensor decode wrong");
  raw_sense_a: assert property (rawCurrentOn == (channelSelect == 6'h1E))
    else $error("raw current decode wrong");
  clamp_ref_a: assert property ((clampRefOn == (channelSelect == 6'h1F))
    && (channelValid == !channelSelect[5])) else $error("clamp or range decode wrong");
endmodule // acr_ctrl_chk

bind acr_converter_control acr_ctrl_chk u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .paddr(paddr), .pslverr(pslverr), .channelSelect(channelSelect),
  .channelValid(channelValid), .tempSensorOn(tempSensorOn), .bandgapOn(bandgapOn),
  .rawCurrentOn(rawCurrentOn), .clampRefOn(clampRefOn),
  .referenceSelect(referenceSelect), .externalRefOn(externalRefOn),
  .converterPowered(converterPowered), .sampleHold(sampleHold)
);

// ### test/acr_front_end.sv
// Model of the analog front end: comparator and internal oscillator.
`timescale 1ns/100ps
module acr_front_end #(
  parameter logic [9:0] LEVEL = 10'h2A5
) (
  // Converter side.
  input  wire logic [9:0] trialCode,
  input  wire logic       sampleHold,
  // Comparator and oscillator.
  output logic            compareIn,
  output logic            rcOscPin
);
  // The trial bit is kept while the held level is not below the trial word.
  assign compareIn = sampleHold ? (LEVEL >= trialCode) : 1'b0;
  // The oscillator runs free with no phase tie to the core clock.
  initial begin
    rcOscPin = 1'b0;
    forever #53 rcOscPin = ~rcOscPin;
  end
endmodule // acr_front_end

// ### test/tb_top.sv
// Self-checking bench of the converter control block.
`timescale 1ns/100ps
module tb_top;
  localparam logic [9:0] LEVEL = 10'h2A6;
  logic        core_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rcOscPin;
  logic        compareIn;
  logic [5:0]  channelSelect;
  logic        channelValid;
  logic [1:0]  referenceSelect;
  logic        externalRefOn;
  logic        converterPowered;
  logic        sampleHold;
  logic [9:0]  trialCode;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          cnt;
  logic [7:0]  addrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [5:0]  chs [8] = '{6'h00, 6'h07, 6'h10, 6'h11, 6'h1E, 6'h1F, 6'h20, 6'h3F};
  ////////////////////////////////////////////////////////////
  // Design, front-end model and clock.
  acr_converter_control u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rcOscPin(rcOscPin), .compareIn(compareIn),
    .channelSelect(channelSelect), .channelValid(channelValid), .tempSensorOn(),
    .bandgapOn(), .rawCurrentOn(), .clampRefOn(), .referenceSelect(referenceSelect),
    .externalRefOn(externalRefOn), .converterPowered(converterPowered),
    .sampleHold(sampleHold), .trialCode(trialCode), .irq(irq)
  );
  acr_front_end #(.LEVEL(LEVEL)) u_afe (
    .trialCode(trialCode), .sampleHold(sampleHold),
    .compareIn(compareIn), .rcOscPin(rcOscPin)
  );
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Cycle count for timing conversions.
  always @(posedge core_clk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////
  // One APB transfer, entered just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Read a register and compare it.
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // Run one conversion with a clock code and format, then check time and result.
  task automatic conv(input logic [2:0] c, input logic j, input int d);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = j ? {6'h0, LEVEL[9:8]} : LEVEL[9:2];
    lo = j ? LEVEL[7:0] : {LEVEL[1:0], 6'h0};
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h04, {25'h0, c, 1'b0, j, 2'b00});
    apb(1'b1, 8'h00, 32'h3);
    cnt = cyc;
    do apb(1'b0, 8'h00, 32'h0); while (rd[1] === 1'b1);
    cnt = cyc - cnt;
    chk("conversion time", 1, cnt >= 10 * d && cnt <= 13 * d + 20);
    rdc(8'h10, 32'h1, "done flag");
    rdc(8'h08, {24'h0, hi}, "result high");
    rdc(8'h0C, {24'h0, lo}, "result low");
  endtask
  // Closing report and verdict.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake or conversion.
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    foreach (addrs[i]) rdc(addrs[i], 32'h0, "reset value");
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 8'h04, 32'hFF);
    rdc(8'h04, 32'h77, "clock reg mask");
    $display("test map done");
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 8'h04, r);
      chk("reference field", r, referenceSelect);
      chk("external ref", r / 2, externalRefOn);
    end
    foreach (chs[i]) begin
      apb(1'b1, 8'h00, {24'h0, chs[i], 2'b01});
      chk("channel", chs[i], channelSelect);
      chk("channel valid", chs[i] <= 6'h1F, channelValid);
      chk("powered", 1, converterPowered);
    end
    $display("test decode done");
    apb(1'b1, 8'h04, 32'h00);
    apb(1'b1, 8'h00, 32'h3);
    rdc(8'h00, 32'h1, "reserved 000");
    apb(1'b1, 8'h04, 32'h40);
    apb(1'b1, 8'h00, 32'h3);
    rdc(8'h00, 32'h1, "reserved 100");
    conv(3'h1, 1'b1, 8);
    conv(3'h5, 1'b0, 16);
    conv(3'h2, 1'b1, 32);
    conv(3'h6, 1'b1, 64);
    conv(3'h3, 1'b0, 66);
    $display("test conversions done");
    apb(1'b1, 8'h14, 32'h0);
    chk("irq masked", 0, irq);
    apb(1'b1, 8'h14, 32'h1);
    chk("irq raised", 1, irq);
    apb(1'b1, 8'h10, 32'h1);
    chk("irq cleared", 0, irq);
    rdc(8'h10, 32'h0, "flag cleared");
    $display("test interrupt done");
    apb(1'b1, 8'h04, 32'h60);
    apb(1'b1, 8'h00, 32'h3);
    repeat (100) @(posedge core_clk);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h00, 32'h3);
    rdc(8'h00, 32'h1, "start in hold-off");
    rdc(8'h10, 32'h0, "no flag on abort");
    rdc(8'h08, {24'h0, LEVEL[9:2]}, "kept result");
    repeat (200) @(posedge core_clk);
    apb(1'b1, 8'h00, 32'h3);
    rdc(8'h00, 32'h3, "start after hold-off");
    $display("test abort done");
    apb(1'b1, 8'h00, 32'h0);
    repeat (200) @(posedge core_clk);
    apb(1'b1, 8'h00, 32'h2);
    rdc(8'h00, 32'h0, "start while off");
    chk("idle while off", 0, sampleHold);
    chk("unpowered", 0, converterPowered);
    $display("test disable done");
    end_of_test();
  end
endmodule // tb_top
